// file: verilog/fcrc_pkg.sv
package fcrc_pkg;
  // APB register byte offsets
  localparam logic [7:0] ADDR_MODE = 8'h00;
  localparam logic [7:0] ADDR_CMD = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_RESULT = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_ST = 8'h10;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;
  // Mode register fields and reset values
  localparam int MODE_IE_BIT = 0;
  localparam int MODE_WS_LSB = 8;
  localparam logic [3:0] WS_RESET = 4'h0;
  // Command register fields
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_ARG_LSB = 8;
  localparam int CMD_KEY_LSB = 24;
  localparam logic [7:0] CMD_KEY = 8'h5a; // Arbitrary key value
  // Status register bits
  localparam int ST_READY_BIT = 0;
  localparam int ST_CMD_ERR_BIT = 1;
  localparam int ST_LOCK_ERR_BIT = 2;
  // Array geometry
  localparam int LINE_AW = 13; // 128 KiB in 16-byte lines
  localparam int LINE_LSB = 4;
  localparam int NUM_LOCK = 16;
  localparam int REGION_LSB = 5; // 32 pages per region
  // Descriptor contents
  localparam logic [31:0] DESC_ID = 32'h00000001; // Arbitrary id value
  localparam logic [31:0] FLASH_BYTES = 32'h00020000;
  localparam logic [31:0] PAGE_BYTES = 32'h00000100;
  localparam logic [31:0] NUM_PLANES = 32'h00000001;
  localparam logic [31:0] REGION_BYTES = 32'h00002000;
  localparam logic [4:0] DESC_LOCK0 = 5'h06;
  localparam logic [4:0] DESC_WORDS = 5'h16;

  // Command opcodes
  typedef enum logic [3:0] {
    OP_GET_DESC = 4'h0, OP_WRITE = 4'h1, OP_WRITE_LOCK = 4'h2,
    OP_ERASE_WRITE = 4'h3, OP_ERASE_WRITE_LOCK = 4'h4,
    OP_ERASE_ALL = 4'h5, OP_SET_LOCK = 4'h8, OP_CLEAR_LOCK = 4'h9,
    OP_GET_LOCK = 4'ha, OP_SET_NV = 4'hb, OP_CLEAR_NV = 4'hc,
    OP_GET_NV = 4'hd
  } fcrc_op_e;

  // Command sequencer states, Gray from CMD_IDLE to CMD_RUN to CMD_FINISH only
  typedef enum logic [1:0] {
    CMD_IDLE = 2'b00, CMD_RUN = 2'b01, CMD_FINISH = 2'b11
  } fcrc_cmd_e;

  // Descriptor word by index, zero past the end
  function automatic logic [31:0] fcrc_desc_word(input logic [4:0] idx);
    if (idx == 5'h00) fcrc_desc_word = DESC_ID;
    else if (idx == 5'h01) fcrc_desc_word = FLASH_BYTES;
    else if (idx == 5'h02) fcrc_desc_word = PAGE_BYTES;
    else if (idx == 5'h03) fcrc_desc_word = NUM_PLANES;
    else if (idx == 5'h04) fcrc_desc_word = FLASH_BYTES;
    else if (idx == 5'h05) fcrc_desc_word = 32'(NUM_LOCK);
    else if (idx < DESC_WORDS) fcrc_desc_word = REGION_BYTES;
    else fcrc_desc_word = 32'h00000000;
  endfunction
endpackage

// file: verilog/fcrc_ws_timer.sv
`timescale 1ns/10ps
// Counts programmed wait states for one array line read
module fcrc_ws_timer (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic start,
  input wire logic [3:0] waitStates,
  output logic busy,
  output logic done
);
  typedef struct packed {
    logic [3:0] cnt; // Remaining wait states
    logic busy; // Read in progress
    logic done; // One-cycle completion pulse
  } fcrc_tmr_s;

  fcrc_tmr_s q, d;

  // Next state
  always_comb begin
    d = q;
    d.done = 1'b0;
    if (start) begin
      d.cnt = waitStates;
      d.busy = 1'b1;
    end else if (q.busy) begin
      if (q.cnt == 4'h0) begin
        d.busy = 1'b0;
        d.done = 1'b1;
      end else begin
        d.cnt = q.cnt - 4'h1;
      end
    end
  end

  // State register
  always_ff @(posedge core_clk) begin
    if (rst) q <= '0;
    else q <= d;
  end

  assign busy = q.busy;
  assign done = q.done;
endmodule // fcrc_ws_timer

// file: verilog/fcrc_cmd_check.sv
`timescale 1ns/10ps
// Checks key, opcode and lock protection of a command word
module fcrc_cmd_check (
  input wire logic [31:0] cmdWord,
  input wire logic [15:0] lockBits,
  output logic keyOk,
  output logic opValid,
  output logic touchesArray,
  output logic inLocked
);
  logic [3:0] op;
  logic [15:0] page;
  logic [3:0] region;

  // Field extraction
  always_comb begin
    op = cmdWord[fcrc_pkg::CMD_OP_LSB +: 4];
    page = cmdWord[fcrc_pkg::CMD_ARG_LSB +: 16];
    region = page[fcrc_pkg::REGION_LSB +: 4];
    keyOk = cmdWord[fcrc_pkg::CMD_KEY_LSB +: 8] == fcrc_pkg::CMD_KEY;
    opValid = (op <= 4'h5) || ((op >= 4'h8) && (op <= 4'hd));
    touchesArray = (op >= 4'h1) && (op <= 4'h5);
    // Erase all is refused if any region is protected
    if (op == fcrc_pkg::OP_ERASE_ALL) inLocked = |lockBits;
    else inLocked = lockBits[region];
  end
endmodule // fcrc_cmd_check

// file: verilog/fcrc_flash_ctrl.sv
`timescale 1ns/10ps
// What this block does
// - Serve byte, half-word and word reads
// - Array aliases across the whole address space
// - Read latency follows wait states, zero is single
// - Two code line buffers speed sequential fetch
// - Small wait states: first slow, rest single
// - Large wait states: new line reloads cost less
// - Data buffer prefetches next line on second read
// - Reads wait while a command runs
// - Decode the twelve command opcodes
// - Command write clears ready and result
// - Completion sets ready and may interrupt
// - Bad key or opcode sets command error
// - Locked target sets lock error
// - Interrupt on ready, command error or lock error rising
// - Result reads walk descriptor, then zero
module fcrc_flash_ctrl (
  input wire logic core_clk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic pslverr,
  output logic [31:0] prdata,
  // Processor read port
  input wire logic rdReq,
  input wire logic rdCode,
  input wire logic [31:0] rdAddr,
  input wire logic [1:0] rdSize,
  output logic rdAck,
  output logic [31:0] rdData,
  // Flash array read side
  output logic flashRdEn,
  output logic [12:0] flashRdLine,
  input wire logic [127:0] flashRdata,
  // Flash array command side
  output logic flashCmdStart,
  output logic [3:0] flashCmdOp,
  output logic [15:0] flashCmdArg,
  input wire logic flashCmdDone,
  input wire logic [31:0] flashCmdValue,
  input wire logic [15:0] lockBits,
  // Interrupt
  output logic irq
);
  // Fill destinations of the line fetch engine
  localparam logic [1:0] DEST_CODE0 = 2'h0;
  localparam logic [1:0] DEST_CODE1 = 2'h1;
  localparam logic [1:0] DEST_DATA = 2'h2;

  typedef struct packed {
    logic [127:0] cb0; // Code buffer 0 data
    logic [127:0] cb1; // Code buffer 1 data
    logic [127:0] db; // Data buffer
    logic [12:0] ct0; // Code buffer 0 line tag
    logic [12:0] ct1; // Code buffer 1 line tag
    logic [12:0] dt; // Data buffer line tag
    logic cv0; // Tags valid
    logic cv1;
    logic dv;
    logic curBuf; // Code buffer last served
    logic dPf; // Data prefetch already issued
    logic fActive; // Line fetch in flight
    logic [12:0] fLine; // Line being fetched
    logic [1:0] fDest; // Where the fetched line goes
    logic rdAck; // Read answer
    logic [31:0] rdData;
    logic rdyIe; // Mode register
    logic [3:0] ws;
    logic ready; // Status flags
    logic cmdErr;
    logic lockErr;
    logic [31:0] result; // Result value
    logic descMode; // Result reads walk the descriptor
    logic [4:0] descIdx;
    logic [2:0] irqSt; // Sticky events
    logic [2:0] irqMask;
    logic irq;
    fcrc_pkg::fcrc_cmd_e cmdSt; // Command sequencer
    logic flashCmdStart;
    logic [3:0] flashCmdOp;
    logic [15:0] flashCmdArg;
    logic pready; // APB answer
    logic pslverr;
    logic [31:0] prdata;
  } fcrc_state_s;

  fcrc_state_s q, d;
  logic fetchStart; // Kicks the wait-state timer
  logic tmBusy;
  logic tmDone;
  logic keyOk;
  logic opValid;
  logic touchesArray;
  logic inLocked;
  logic [12:0] reqLine; // Requested line, high bits dropped
  logic hit;
  logic [127:0] hitLine;
  logic apbAccess; // First access-phase cycle
  logic apbCommit; // Completing edge of a transfer

  // Format a word of a line at the requested width
  function automatic logic [31:0] fmtRead(input logic [127:0] line,
    input logic [3:0] a, input logic [1:0] sz);
    logic [31:0] w;
    w = line[a[3:2]*32 +: 32];
    case (sz)
      2'h0: fmtRead = {24'h000000, w[a[1:0]*8 +: 8]}; // Byte
      2'h1: fmtRead = {16'h0000, w[a[1]*16 +: 16]}; // Half-word
      default: fmtRead = w; // Word
    endcase
  endfunction

  // Wait-state counter for array reads
  fcrc_ws_timer u_timer (
    .core_clk(core_clk),
    .rst(rst),
    .start(fetchStart),
    .waitStates(q.ws),
    .busy(tmBusy),
    .done(tmDone)
  );

  // Key, opcode and lock screening of the bus write data
  fcrc_cmd_check u_check (
    .cmdWord(pwdata),
    .lockBits(lockBits),
    .keyOk(keyOk),
    .opValid(opValid),
    .touchesArray(touchesArray),
    .inLocked(inLocked)
  );

  // Bus phase decode
  assign apbAccess = psel && penable && !q.pready;
  assign apbCommit = psel && penable && q.pready;
  assign reqLine = rdAddr[fcrc_pkg::LINE_LSB +: fcrc_pkg::LINE_AW];

  // Next-state logic for the whole controller
  always_comb begin
    d = q;
    d.rdAck = 1'b0;
    d.flashCmdStart = 1'b0;
    d.pready = 1'b0;
    d.pslverr = 1'b0;
    fetchStart = 1'b0;
    hit = 1'b0;
    hitLine = '0;

    // Land a finished line fetch in its buffer
    if (tmDone && q.fActive) begin
      d.fActive = 1'b0;
      case (q.fDest)
        DEST_CODE0: begin
          d.cb0 = flashRdata;
          d.ct0 = q.fLine;
          d.cv0 = 1'b1;
        end
        DEST_CODE1: begin
          d.cb1 = flashRdata;
          d.ct1 = q.fLine;
          d.cv1 = 1'b1;
        end
        default: begin
          // Prefetch overwrites the data line in place
          d.db = flashRdata;
          d.dt = q.fLine;
          d.dv = 1'b1;
        end
      endcase
    end

    // Serve a read; held off while a command runs
    if (rdReq && !q.rdAck && q.cmdSt == fcrc_pkg::CMD_IDLE) begin
      if (rdCode) begin
        // Instruction fetch through the two code buffers
        if (d.cv0 && d.ct0 == reqLine) begin
          hit = 1'b1;
          hitLine = d.cb0;
          d.curBuf = 1'b0;
        end else if (d.cv1 && d.ct1 == reqLine) begin
          hit = 1'b1;
          hitLine = d.cb1;
          d.curBuf = 1'b1;
        end else if (!d.fActive && !tmBusy) begin
          // Miss: demand fetch costs the wait states
          fetchStart = 1'b1;
          d.fLine = reqLine;
          d.fDest = {1'b0, ~q.curBuf};
        end
        // After a hit, fetch the next line into the other buffer
        if (hit && !d.fActive && !tmBusy) begin
          if (!((d.curBuf ? d.cv0 : d.cv1) &&
              (d.curBuf ? d.ct0 : d.ct1) == reqLine + 13'h1)) begin
            fetchStart = 1'b1;
            d.fLine = reqLine + 13'h1;
            d.fDest = {1'b0, ~d.curBuf};
          end
        end
      end else begin
        // Data read through the single data buffer
        if (d.dv && d.dt == reqLine) begin
          hit = 1'b1;
          hitLine = d.db;
          // Second read of the line starts the next one, not the fill
          if (q.dv && q.dt == reqLine && !q.dPf && !d.fActive &&
              !tmBusy) begin
            fetchStart = 1'b1;
            d.fLine = reqLine + 13'h1;
            d.fDest = DEST_DATA;
            d.dPf = 1'b1;
          end
        end else if (!d.fActive && !tmBusy) begin
          fetchStart = 1'b1;
          d.fLine = reqLine;
          d.fDest = DEST_DATA;
          d.dPf = 1'b0;
        end
      end
      if (hit) begin
        d.rdAck = 1'b1;
        d.rdData = fmtRead(hitLine, rdAddr[3:0], rdSize);
      end
    end
    if (fetchStart) d.fActive = 1'b1;

    // Register read data, captured in the first access cycle
    if (apbAccess) begin
      d.pready = 1'b1;
      d.prdata = 32'h00000000;
      case (paddr)
        fcrc_pkg::ADDR_MODE: begin
          d.prdata[fcrc_pkg::MODE_IE_BIT] = q.rdyIe;
          d.prdata[fcrc_pkg::MODE_WS_LSB +: 4] = q.ws;
        end
        fcrc_pkg::ADDR_CMD: d.prdata = 32'h00000000;
        fcrc_pkg::ADDR_STATUS: begin
          d.prdata[fcrc_pkg::ST_READY_BIT] = q.ready;
          d.prdata[fcrc_pkg::ST_CMD_ERR_BIT] = q.cmdErr;
          d.prdata[fcrc_pkg::ST_LOCK_ERR_BIT] = q.lockErr;
        end
        fcrc_pkg::ADDR_RESULT: d.prdata = q.result;
        fcrc_pkg::ADDR_IRQ_ST: d.prdata[2:0] = q.irqSt;
        fcrc_pkg::ADDR_IRQ_MASK: d.prdata[2:0] = q.irqMask;
        default: d.pslverr = 1'b1; // Unmapped address
      endcase
    end else if (apbCommit) begin
      // Drop pready after the completing edge
      d.pready = 1'b0;
    end

    // Read side effects at the completing edge
    if (apbCommit && !pwrite) begin
      if (paddr == fcrc_pkg::ADDR_STATUS) begin
        d.cmdErr = 1'b0;
        d.lockErr = 1'b0;
      end
      if (paddr == fcrc_pkg::ADDR_RESULT && q.descMode) begin
        // Each result read steps to the next word, holding at index 31
        d.descIdx = (q.descIdx == 5'h1f) ? q.descIdx : q.descIdx + 5'h1;
        d.result = fcrc_pkg::fcrc_desc_word(d.descIdx);
      end
    end

    // Register writes at the completing edge
    if (apbCommit && pwrite) begin
      case (paddr)
        fcrc_pkg::ADDR_MODE: begin
          d.rdyIe = pwdata[fcrc_pkg::MODE_IE_BIT];
          d.ws = pwdata[fcrc_pkg::MODE_WS_LSB +: 4];
        end
        fcrc_pkg::ADDR_CMD: begin
          if (q.cmdSt == fcrc_pkg::CMD_IDLE) begin
            d.ready = 1'b0;
            d.result = 32'h00000000;
            d.descMode = 1'b0;
            d.cmdSt = fcrc_pkg::CMD_FINISH;
            if (!keyOk || !opValid) begin
              d.cmdErr = 1'b1;
            end else if (touchesArray && inLocked) begin
              d.lockErr = 1'b1;
            end else if (pwdata[3:0] == fcrc_pkg::OP_GET_DESC) begin
              // Descriptor is served from this block
              d.descMode = 1'b1;
              d.descIdx = 5'h00;
              d.result = fcrc_pkg::fcrc_desc_word(5'h00);
            end else begin
              // Hand a valid command to the array
              d.flashCmdStart = 1'b1;
              d.flashCmdOp = pwdata[fcrc_pkg::CMD_OP_LSB +: 4];
              d.flashCmdArg = pwdata[fcrc_pkg::CMD_ARG_LSB +: 16];
              d.cmdSt = fcrc_pkg::CMD_RUN;
            end
          end
        end
        fcrc_pkg::ADDR_IRQ_ST: d.irqSt = q.irqSt & ~pwdata[2:0];
        fcrc_pkg::ADDR_IRQ_MASK: d.irqMask = pwdata[2:0];
        default: d.irqMask = q.irqMask; // Ignored write
      endcase
    end

    // Command sequencer
    case (q.cmdSt)
      fcrc_pkg::CMD_IDLE: d.cmdSt = d.cmdSt;
      fcrc_pkg::CMD_RUN: begin
        // Array busy until it reports completion
        if (flashCmdDone) begin
          d.result = flashCmdValue;
          d.cmdSt = fcrc_pkg::CMD_FINISH;
        end
      end
      fcrc_pkg::CMD_FINISH: begin
        d.ready = 1'b1;
        d.cmdSt = fcrc_pkg::CMD_IDLE;
        // Contents may have changed, drop buffered lines
        d.cv0 = 1'b0;
        d.cv1 = 1'b0;
        d.dv = 1'b0;
      end
      default: d.cmdSt = fcrc_pkg::CMD_IDLE;
    endcase

    // Sticky events, set wins over a same-cycle clear
    if (d.ready && !q.ready) d.irqSt[0] = 1'b1;
    if (d.cmdErr && !q.cmdErr) d.irqSt[1] = 1'b1;
    if (d.lockErr && !q.lockErr) d.irqSt[2] = 1'b1;
    // Ready event also needs the mode enable
    d.irq = |(d.irqSt & d.irqMask & {2'b11, d.rdyIe});
  end

  // State register
  always_ff @(posedge core_clk) begin
    if (rst) begin
      q <= '0;
      q.ws <= fcrc_pkg::WS_RESET;
      q.ready <= 1'b1;
      q.cmdSt <= fcrc_pkg::CMD_IDLE;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from flops
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign prdata = q.prdata;
  assign rdAck = q.rdAck;
  assign rdData = q.rdData;
  assign flashRdEn = q.fActive;
  assign flashRdLine = q.fLine;
  assign flashCmdStart = q.flashCmdStart;
  assign flashCmdOp = q.flashCmdOp;
  assign flashCmdArg = q.flashCmdArg;
  assign irq = q.irq;
endmodule // fcrc_flash_ctrl

// file: test/fcrc_asserts.sv
`timescale 1ns/10ps
// Port-level watch on bus, read and command sequencing
module fcrc_asserts (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic rdReq,
  input wire logic rdAck,
  input wire logic flashCmdStart,
  input wire logic [3:0] flashCmdOp,
  input wire logic irq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  logic cmdWr; // Keyed write accepted at the command offset
  assign cmdWr = psel && pready && pwrite &&
    paddr == fcrc_pkg::ADDR_CMD && pwdata[31:24] == fcrc_pkg::CMD_KEY;
  a_reset_quiet: assert property (
    $fell(rst) |-> !pready && !rdAck && !irq && !flashCmdStart)
    else $error("outputs busy after reset");
  a_apb_wait: assert property (psel && $rose(penable) |=> pready)
    else $error("pready late");
  a_pready_pulse: assert property (pready |=> !pready)
    else $error("pready held");
  a_slverr_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_ack_pulse: assert property (rdAck |=> !rdAck)
    else $error("rdAck held");
  a_ack_req: assert property (rdAck |-> $past(rdReq))
    else $error("rdAck without request");
  a_read_bound: assert property ($rose(rdReq) |-> ##[1:60] rdAck)
    else $error("read never answered");
  a_start_cause: assert property (
    flashCmdStart |-> $past(cmdWr) || $past(cmdWr, 2))
    else $error("command start without keyed write");
  a_op_legal: assert property (
    flashCmdStart |-> flashCmdOp inside {[4'h1:4'h5], [4'h8:4'hd]})
    else $error("illegal opcode sent to array");
  a_cmd_blocks: assert property (flashCmdStart |=> !rdAck [*4])
    else $error("read answered during command");
endmodule // fcrc_asserts

bind fcrc_flash_ctrl fcrc_asserts u_chk (.core_clk(core_clk), .rst(rst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .rdReq(rdReq),
  .rdAck(rdAck), .flashCmdStart(flashCmdStart),
  .flashCmdOp(flashCmdOp), .irq(irq));

// file: test/fcrc_flash_model.sv
`timescale 1ns/10ps
// Array stand-in: line pattern and delayed command completion
module fcrc_flash_model #(parameter int DoneDly = 20) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic flashRdEn,
  input wire logic [12:0] flashRdLine,
  input wire logic flashCmdStart,
  input wire logic [3:0] flashCmdOp,
  input wire logic [15:0] flashCmdArg,
  output logic [127:0] flashRdata,
  output logic flashCmdDone,
  output logic [31:0] flashCmdValue
);
  logic [127:0] pat; // Word k of a line tagged with line and k
  logic [7:0] cnt; // Countdown of the running command
  logic [19:0] cmdSeen; // Opcode and argument in flight
  // Idle bus shows the inverse, never a stale line
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      pat[32*k +: 32] = {flashRdLine, 1'b0, 2'(k), 16'hc3a5};
    end
    flashRdata = flashRdEn ? pat : ~pat;
  end
  // Slow completion so reads must stall meanwhile
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cnt <= 8'h00;
      cmdSeen <= 20'h0;
    end else if (flashCmdStart) begin
      cnt <= 8'(DoneDly);
      cmdSeen <= {flashCmdOp, flashCmdArg};
    end else if (cnt != 8'h00) begin
      cnt <= cnt - 8'h01;
    end
  end
  assign flashCmdDone = (cnt == 8'h01);
  assign flashCmdValue = flashCmdDone ? {12'h0, cmdSeen} : ~{12'h0, cmdSeen};
endmodule // fcrc_flash_model

// file: test/testbench.sv
`timescale 1ns/10ps
module testbench;
  localparam logic [7:0] MD = fcrc_pkg::ADDR_MODE;
  localparam logic [7:0] ST = fcrc_pkg::ADDR_STATUS;
  localparam logic [7:0] RS = fcrc_pkg::ADDR_RESULT;
  localparam logic [7:0] IS = fcrc_pkg::ADDR_IRQ_ST;
  localparam logic [7:0] IM = fcrc_pkg::ADDR_IRQ_MASK;
  localparam logic [7:0] KEY = fcrc_pkg::CMD_KEY;
  logic core_clk, rst, psel, penable, pwrite, pready, pslverr, sErr;
  logic rdReq, rdCode, rdAck, flashRdEn, flashCmdStart, flashCmdDone, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdAddr, rdData, flashCmdValue, q;
  logic [1:0] rdSize;
  logic [12:0] flashRdLine;
  logic [127:0] flashRdata;
  logic [3:0] flashCmdOp, seenOp;
  logic [15:0] flashCmdArg, lockBits;
  int err_count, compares, cyc, lat, startCnt;
  logic [3:0] ws [3] = '{4'h0, 4'h3, 4'h6};
  logic [3:0] ops [11] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h8, 4'h9,
    4'ha, 4'hb, 4'hc, 4'hd};
  logic [31:0] wa [4] = '{32'h13, 32'h00100022, 32'h20000048, 32'h00020048};
  logic [31:0] dtab [6] = '{fcrc_pkg::DESC_ID, 32'h20000, 32'h100, 32'h1,
    32'h20000, 32'h10};

  fcrc_flash_ctrl u_dut (.core_clk(core_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .pslverr(pslverr), .prdata(prdata), .rdReq(rdReq),
    .rdCode(rdCode), .rdAddr(rdAddr), .rdSize(rdSize), .rdAck(rdAck),
    .rdData(rdData), .flashRdEn(flashRdEn), .flashRdLine(flashRdLine),
    .flashRdata(flashRdata), .flashCmdStart(flashCmdStart),
    .flashCmdOp(flashCmdOp), .flashCmdArg(flashCmdArg),
    .flashCmdDone(flashCmdDone), .flashCmdValue(flashCmdValue),
    .lockBits(lockBits), .irq(irq));
  fcrc_flash_model u_arr (.core_clk(core_clk), .rst(rst),
    .flashRdEn(flashRdEn), .flashRdLine(flashRdLine),
    .flashCmdStart(flashCmdStart), .flashCmdOp(flashCmdOp),
    .flashCmdArg(flashCmdArg), .flashRdata(flashRdata),
    .flashCmdDone(flashCmdDone), .flashCmdValue(flashCmdValue));

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  // Hang guard and command start monitor
  always @(posedge core_clk) begin
    cyc++;
    if (flashCmdStart === 1'b1) begin
      startCnt++;
      seenOp = flashCmdOp;
    end
    if (cyc == 20000) begin
      err_count++;
      close_out();
    end
  end

  task automatic close_out;
    $display("Errors %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  // One APB transfer, held until pready
  task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    q = prdata;
    sErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask
  // One processor read, held until rdAck
  task automatic rd(input logic code, input logic [31:0] a,
      input logic [1:0] sz);
    rdReq <= 1'b1;
    rdCode <= code;
    rdAddr <= a;
    rdSize <= sz;
    lat = 0;
    do begin
      @(posedge core_clk);
      lat++;
    end while (rdAck !== 1'b1);
    q = rdData;
    rdReq <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic cmd(input logic [3:0] op, input logic [15:0] arg,
      input logic [7:0] k);
    apb(1'b1, fcrc_pkg::ADDR_CMD, {k, arg, 4'h0, op});
  endtask
  task automatic stat(input logic [31:0] e);
    repeat (4) @(posedge core_clk);
    apb(1'b0, ST, 32'h0);
    chk(q, e);
  endtask
  task automatic waitRdy;
    do begin
      apb(1'b0, ST, 32'h0);
    end while (q[0] !== 1'b1);
  endtask
  // Expected lanes: line tag pattern, right-justified
  function automatic logic [31:0] expd(input logic [31:0] a,
      input logic [1:0] sz);
    logic [31:0] w;
    w = {a[16:4], 1'b0, a[3:2], 16'hc3a5};
    if (sz == 2'h0) expd = {24'h0, w[8*a[1:0] +: 8]};
    else if (sz == 2'h1) expd = {16'h0, w[16*a[1] +: 16]};
    else expd = w;
  endfunction

  initial begin
    {rst, psel, penable, pwrite, rdReq, rdCode} = 6'h20;
    paddr = 8'h00;
    pwdata = 32'h0;
    rdAddr = 32'h0;
    rdSize = 2'h0;
    lockBits = 16'h0;
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    apb(1'b0, ST, 32'h0);
    chk(q, 32'h1);
    apb(1'b0, 8'h40, 32'h0);
    chk({31'h0, sErr}, 32'h1);
    foreach (wa[i]) begin
      rd(1'b0, wa[i], 2'(i % 3));
      chk(q, expd(wa[i], 2'(i % 3)));
    end
    // Sequential fetch runs, every other one with a gap
    foreach (ws[j]) begin
      apb(1'b1, MD, {20'h0, ws[j], 8'h00});
      for (int k = 0; k < 8; k++) begin
        if (k % 2 == 1) repeat (3) @(posedge core_clk);
        rd(1'b1, 32'h400 * (j + 1) + 4 * k, 2'h2);
        chk(q, expd(32'h400 * (j + 1) + 4 * k, 2'h2));
        if (k == 0) chk(lat, ws[j] + 4);
        else if (k != 4) chk(lat, 2);
      end
    end
    apb(1'b1, MD, 32'h100);
    for (int k = 0; k < 8; k++) begin
      rd(1'b0, 32'h1000 + 4 * k, 2'h2);
      chk(q, expd(32'h1000 + 4 * k, 2'h2));
      if (k == 1) chk(lat, 2);
    end
    // Refused commands
    cmd(4'h1, 16'h3, 8'ha5);
    stat(32'h3);
    apb(1'b0, ST, 32'h0);
    chk(q, 32'h1);
    cmd(4'h6, 16'h3, KEY);
    stat(32'h3);
    lockBits <= 16'h1;
    cmd(4'h1, 16'h3, KEY);
    stat(32'h5);
    cmd(4'h5, 16'h0, KEY);
    stat(32'h5);
    chk(startCnt, 0);
    lockBits <= 16'h0;
    // Every array command, one read stalled behind the first
    foreach (ops[i]) begin
      cmd(ops[i], 16'h20 + 16'(i), KEY);
      apb(1'b0, ST, 32'h0);
      chk(q, 32'h0);
      apb(1'b0, RS, 32'h0);
      chk(q, 32'h0);
      if (i == 0) begin
        rd(1'b0, 32'h2000, 2'h2);
        chk(32'(lat > 12), 32'h1);
      end
      waitRdy();
      chk(32'(seenOp), 32'(ops[i]));
      apb(1'b0, RS, 32'h0);
      chk(q, {12'h0, ops[i], 16'h20 + 16'(i)});
    end
    chk(startCnt, 11);
    cmd(4'h0, 16'h0, KEY);
    waitRdy();
    for (int i = 0; i < 24; i++) begin
      apb(1'b0, RS, 32'h0);
      chk(q, i < 6 ? dtab[i] : i < 22 ? 32'h2000 : 32'h0);
    end
    // Interrupt raise, clear, mask
    apb(1'b1, IS, 32'h7);
    apb(1'b1, IM, 32'h1);
    apb(1'b1, MD, 32'h1);
    cmd(4'h8, 16'h0, KEY);
    waitRdy();
    chk(32'(irq), 32'h1);
    apb(1'b0, IS, 32'h0);
    chk(q, 32'h1);
    apb(1'b1, IS, 32'h1);
    apb(1'b0, ST, 32'h0);
    chk(32'(irq), 32'h0);
    apb(1'b1, IM, 32'h2);
    cmd(4'h1, 16'h0, 8'h00);
    stat(32'h3);
    chk(32'(irq), 32'h1);
    apb(1'b1, IS, 32'h2);
    @(posedge core_clk);
    chk(32'(irq), 32'h0);
    apb(1'b1, IM, 32'h0);
    cmd(4'h1, 16'h0, 8'h00);
    stat(32'h3);
    chk(32'(irq), 32'h0);
    close_out();
  end
endmodule // testbench
